// File: src/dram_pkg.sv
// Shared constants, carrier types and states of the display RAM address mapper
package dram_pkg;
	// Display memory geometry
	localparam int COL_BYTES  = 64;
	localparam int ROW_COUNT  = 80;
	localparam int SEG_COUNT  = 128;
	localparam int COL_W      = 6;
	localparam int ROW_W      = 7;
	localparam int SEG_W      = 7;
	localparam int ADDR_W     = COL_W + ROW_W;
	localparam int MEM_DEPTH  = COL_BYTES * ROW_COUNT;
	localparam logic [COL_W-1:0] COL_LAST = 6'h3F;
	localparam logic [7:0] ROW_COUNT_B  = 8'h50;
	localparam logic [7:0] ROW_LAST_B   = 8'h4F;
	// Serial framing
	localparam int BITS_PER_BYTE = 8;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam int SYNC_LANES    = 4;
	// Command bytes
	localparam logic [7:0] CMD_DISPLAY_ON  = 8'hAF;
	localparam logic [7:0] CMD_DISPLAY_OFF = 8'hAE;
	// Timing: delay from display-on command to driver activation
	localparam int CLK_HZ       = 25_000_000;
	localparam int ON_DELAY_MS  = 100;
	localparam int ON_DELAY_CYC = (CLK_HZ / 1000) * ON_DELAY_MS;
	// Buffer sizing
	localparam int FIFO_DEPTH = 16;

	// One received byte with its data/command flag
	typedef struct packed {
		logic       is_data;
		logic [7:0] value;
	} dram_word_t;

	// Write address pointer
	typedef struct packed {
		logic [ROW_W-1:0] row;
		logic [COL_W-1:0] col;
	} dram_ptr_t;

	// Driver power state, Gray along off -> wait -> on
	typedef enum logic [1:0] {
		PWR_OFF  = 2'b00,
		PWR_WAIT = 2'b01,
		PWR_ON   = 2'b11
	} dram_pwr_t;
endpackage : dram_pkg

// File: src/dram_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module dram_fifo
	import dram_pkg::*;
#(
	parameter int WIDTH = 9,
	parameter int DEPTH = FIFO_DEPTH
)(
	input  wire logic             sys_clk_i,
	input  wire logic             nrst_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o
);
	localparam int PW = $clog2(DEPTH);

	// Power-of-two depth keeps pointer wrap free
	initial
	begin
		if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1)
			$error("dram_fifo: DEPTH must be a power of two >= 2");
	end

	logic [WIDTH-1:0] store [0:DEPTH-1];
	logic [PW:0]      wr_ptr;
	logic [PW:0]      rd_ptr;
	logic [PW:0]      next_wr_ptr;
	logic [PW:0]      next_rd_ptr;
	logic             push;
	logic             pop;

	// Full and empty from the extra pointer bit
	always_comb
	begin
		in_ready_o  = (wr_ptr[PW] == rd_ptr[PW]) || (wr_ptr[PW-1:0] != rd_ptr[PW-1:0]);
		out_valid_o = (wr_ptr != rd_ptr);
		out_data_o  = store[rd_ptr[PW-1:0]];
		push        = in_valid_i && in_ready_o;
		pop         = out_valid_o && out_ready_i;
		next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
	end

	// Pointer registers
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end
		else
		begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
		end
	end

	// Storage needs no reset
	always_ff @(posedge sys_clk_i)
	begin
		if (push)
			store[wr_ptr[PW-1:0]] <= in_data_i;
	end
endmodule : dram_fifo
`default_nettype wire

// File: src/dram_core.sv
// Serial receiver, address mapper, display memory and driver power control
//
// What this block does
// [RQ1] Memory 64 bytes by 80 rows, two pixels
// [RQ2] Data/command flag routes byte to memory or command
// [RQ3] Increment bit picks column-first or row-first order
// [RQ4] Column and nibble remap reverse segment mapping
// [RQ5] Common remap and start line shift row order
// [RQ6] Writes confined to programmable column and row window
// [RQ7] Host holds reset low at least 3 us; the bench holds its first reset low for two cycles (80 ns)
// [RQ8] Host waits 3 us before panel supply
// [RQ9] Display-on command enables drivers after 100 ms
// [RQ10] Host sends display-off before removing panel supply
// [RQ11] Host waits 80 ms before removing logic supply
// [RQ12] Pointer wraps at window end, advancing other axis
// [RQ13] Low nibble drives even segment, high nibble odd
`timescale 1ns/10ps
`default_nettype none
module dram_core
	import dram_pkg::*;
#(
	parameter int ON_DELAY_CYCLES = ON_DELAY_CYC
)(
	input  wire logic             sys_clk_i,
	input  wire logic             nrst_i,
	input  wire logic             sclk_i,
	input  wire logic             sdin_i,
	input  wire logic             dc_i,
	input  wire logic             cs_n_i,
	input  wire logic             incr_vertical_i,
	input  wire logic             col_remap_i,
	input  wire logic             nibble_remap_i,
	input  wire logic             com_remap_i,
	input  wire logic [ROW_W-1:0] start_line_i,
	input  wire logic [COL_W-1:0] col_start_i,
	input  wire logic [COL_W-1:0] col_end_i,
	input  wire logic [ROW_W-1:0] row_start_i,
	input  wire logic [ROW_W-1:0] row_end_i,
	input  wire logic             addr_reload_i,
	input  wire logic             scan_req_i,
	input  wire logic [ROW_W-1:0] scan_com_i,
	input  wire logic [SEG_W-1:0] scan_seg_i,
	output logic [3:0]            pixel_o,
	output logic                  pixel_valid_o,
	output logic                  display_on_o,
	output logic [7:0]            cmd_byte_o,
	output logic                  cmd_strobe_o,
	output logic                  overrun_o
);
	localparam int TW = 32;
	// Synchronisers reset to idle link levels (deselected, clock high), so no false edge follows reset
	localparam logic [SYNC_LANES-1:0] SYNC_IDLE = 4'h9;

	initial
	begin
		// The wait state must last at least two cycles before the drivers come on
		if (ON_DELAY_CYCLES < 2)
			$error("dram_core: ON_DELAY_CYCLES must be at least 2");
	end

	// Two-flop synchronisers for all link pins
	logic [SYNC_LANES-1:0] sync1;
	logic [SYNC_LANES-1:0] sync2;
	logic [SYNC_LANES-1:0] pins;
	assign pins = {cs_n_i, dc_i, sdin_i, sclk_i};
	genvar gi;
	generate
		for (gi = 0; gi < SYNC_LANES; gi++)
		begin : g_sync
			always_ff @(posedge sys_clk_i or negedge nrst_i)
			begin
				if (!nrst_i)
				begin
					sync1[gi] <= SYNC_IDLE[gi];
					sync2[gi] <= SYNC_IDLE[gi];
				end
				else
				begin
					sync1[gi] <= pins[gi];
					sync2[gi] <= sync1[gi];
				end
			end
		end
	endgenerate

	// Receiver state: edge finder, shifter and one pending byte
	logic       sclk_d;
	logic [2:0] bit_cnt;
	logic [6:0] shreg;
	logic       pend_valid;
	dram_word_t pend_word;
	logic       next_sclk_d;
	logic [2:0] next_bit_cnt;
	logic [6:0] next_shreg;
	logic       next_pend_valid;
	dram_word_t next_pend_word;
	logic       next_overrun;
	logic       sclk_rise;
	logic       fifo_in_ready;

	always_comb
	begin
		next_sclk_d     = sync2[0];
		sclk_rise       = sync2[0] && !sclk_d && !sync2[3];
		next_bit_cnt    = bit_cnt;
		next_shreg      = shreg;
		next_pend_valid = pend_valid && !fifo_in_ready;
		next_pend_word  = pend_word;
		next_overrun    = overrun_o;
		if (sync2[3])
			next_bit_cnt = '0;
		else if (sclk_rise)
		begin
			next_shreg   = {shreg[5:0], sync2[1]};
			next_bit_cnt = bit_cnt + 3'h1;
			if (bit_cnt == BIT_LAST)
			begin
				// A byte that finds the buffer still full replaces the stalled one
				next_overrun         = overrun_o || next_pend_valid;
				next_pend_valid      = 1'b1;
				next_pend_word.value = {shreg, sync2[1]};
				// [RQ2] flag sampled with last bit
				next_pend_word.is_data = sync2[2];
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			sclk_d     <= 1'b1;
			bit_cnt    <= '0;
			shreg      <= '0;
			pend_valid <= 1'b0;
			pend_word  <= '0;
			overrun_o  <= 1'b0;
		end
		else
		begin
			sclk_d     <= next_sclk_d;
			bit_cnt    <= next_bit_cnt;
			shreg      <= next_shreg;
			pend_valid <= next_pend_valid;
			pend_word  <= next_pend_word;
			overrun_o  <= next_overrun;
		end
	end

	// Byte buffer; scan reads stall the drain
	dram_word_t word;
	logic       word_valid;
	logic       pop;
	assign pop = word_valid && !scan_req_i;

	dram_fifo #(
		.WIDTH($bits(dram_word_t)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.sys_clk_i  (sys_clk_i),
		.nrst_i     (nrst_i),
		.in_valid_i (pend_valid),
		.in_ready_o (fifo_in_ready),
		.in_data_i  (pend_word),
		.out_valid_o(word_valid),
		.out_ready_i(!scan_req_i),
		.out_data_o (word)
	);

	// Address pointer, command output and power state
	dram_ptr_t     ptr;
	dram_pwr_t     pwr;
	logic [TW-1:0] timer;
	dram_ptr_t     next_ptr;
	dram_pwr_t     next_pwr;
	logic [TW-1:0] next_timer;
	logic [7:0]    next_cmd_byte;
	logic          next_cmd_strobe;
	logic          wr_en;
	logic          is_cmd;
	logic          cmd_on;
	logic          cmd_off;
	logic          col_wrap;
	logic          row_wrap;

	always_comb
	begin
		next_ptr        = ptr;
		next_pwr        = pwr;
		next_timer      = timer;
		next_cmd_byte   = cmd_byte_o;
		is_cmd          = pop && !word.is_data;
		next_cmd_strobe = is_cmd;
		cmd_on          = is_cmd && (word.value == CMD_DISPLAY_ON);
		cmd_off         = is_cmd && (word.value == CMD_DISPLAY_OFF);
		// [RQ6] writes only land inside the window
		wr_en           = pop && word.is_data && (ptr.row < ROW_W'(ROW_COUNT)) &&
			(ptr.col >= col_start_i) && (ptr.col <= col_end_i) &&
			(ptr.row >= row_start_i) && (ptr.row <= row_end_i);
		col_wrap        = (ptr.col == col_end_i);
		row_wrap        = (ptr.row == row_end_i);
		if (is_cmd)
			next_cmd_byte = word.value;
		if (addr_reload_i)
		begin
			next_ptr.col = col_start_i;
			next_ptr.row = row_start_i;
		end
		else if (pop && word.is_data)
		begin
			// [RQ3] horizontal or vertical step
			// [RQ12] wrap and carry into other axis
			if (!incr_vertical_i)
			begin
				next_ptr.col = col_wrap ? col_start_i : ptr.col + 1'b1;
				if (col_wrap)
					next_ptr.row = row_wrap ? row_start_i : ptr.row + 1'b1;
			end
			else
			begin
				next_ptr.row = row_wrap ? row_start_i : ptr.row + 1'b1;
				if (row_wrap)
					next_ptr.col = col_wrap ? col_start_i : ptr.col + 1'b1;
			end
		end
		// [RQ9] delayed driver enable, off at once
		unique case (pwr)
			PWR_OFF:
			begin
				next_timer = '0;
				if (cmd_on)
					next_pwr = PWR_WAIT;
			end
			PWR_WAIT:
			begin
				next_timer = timer + 1'b1;
				if (cmd_off)
					next_pwr = PWR_OFF;
				else if (timer == TW'(ON_DELAY_CYCLES - 1))
					next_pwr = PWR_ON;
			end
			PWR_ON:
			begin
				next_timer = '0;
				if (cmd_off)
					next_pwr = PWR_OFF;
			end
			default:
			begin
				next_timer = '0;
				next_pwr   = PWR_OFF;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			ptr          <= '0;
			pwr          <= PWR_OFF;
			timer        <= '0;
			cmd_byte_o   <= '0;
			cmd_strobe_o <= 1'b0;
			display_on_o <= 1'b0;
		end
		else
		begin
			ptr          <= next_ptr;
			pwr          <= next_pwr;
			timer        <= next_timer;
			cmd_byte_o   <= next_cmd_byte;
			cmd_strobe_o <= next_cmd_strobe;
			display_on_o <= (next_pwr == PWR_ON);
		end
	end

	// Scan address mapping: common to row, segment to byte and nibble
	logic [7:0]       row_sum;
	logic [7:0]       scan_row;
	logic [COL_W-1:0] scan_col;
	logic             scan_hi;
	always_comb
	begin
		// [RQ5] remap reverses order, start line offsets it
		if (com_remap_i)
			row_sum = 8'(start_line_i) + ROW_LAST_B - 8'(scan_com_i);
		else
			row_sum = 8'(start_line_i) + 8'(scan_com_i);
		scan_row = (row_sum >= ROW_COUNT_B) ? row_sum - ROW_COUNT_B : row_sum;
		// [RQ4] reversed columns, swapped nibbles
		scan_col = col_remap_i ? COL_LAST - scan_seg_i[SEG_W-1:1] : scan_seg_i[SEG_W-1:1];
		// [RQ13] odd segment takes high nibble
		scan_hi  = scan_seg_i[0] ^ nibble_remap_i;
	end

	// [RQ1] display memory, registered read
	logic [7:0] display_memory [0:MEM_DEPTH-1];
	logic [7:0] rd_byte;
	always_ff @(posedge sys_clk_i)
	begin
		if (wr_en)
			display_memory[ADDR_W'({ptr.row, ptr.col})] <= word.value;
		rd_byte <= display_memory[ADDR_W'({scan_row[ROW_W-1:0], scan_col})];
	end

	// Second stage picks the nibble
	logic rd_valid;
	logic rd_hi;
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			rd_valid      <= 1'b0;
			rd_hi         <= 1'b0;
			pixel_o       <= '0;
			pixel_valid_o <= 1'b0;
		end
		else
		begin
			rd_valid      <= scan_req_i;
			rd_hi         <= scan_hi;
			pixel_o       <= rd_hi ? rd_byte[7:4] : rd_byte[3:0];
			pixel_valid_o <= rd_valid;
		end
	end

	// Checks on routing, stepping, wrapping and power timing
	a_cmd_route: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [RQ2]
		is_cmd |=> cmd_strobe_o && (cmd_byte_o == $past(word.value)))
		else $error("command byte not routed");
	a_data_no_cmd: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [RQ2]
		(pop && word.is_data) |=> !cmd_strobe_o)
		else $error("data byte raised command strobe");
	a_horiz_step: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [RQ3]
		(pop && word.is_data && !addr_reload_i && !incr_vertical_i && !col_wrap)
		|=> (ptr.col == COL_W'($past(ptr.col) + 1'b1)) && $stable(ptr.row))
		else $error("horizontal step wrong");
	a_vert_step: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [RQ3]
		(pop && word.is_data && !addr_reload_i && incr_vertical_i && !row_wrap)
		|=> (ptr.row == ROW_W'($past(ptr.row) + 1'b1)) && $stable(ptr.col))
		else $error("vertical step wrong");
	a_window_wrap: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [RQ12]
		(pop && word.is_data && !addr_reload_i && col_wrap && row_wrap)
		|=> (ptr.col == $past(col_start_i)) && (ptr.row == $past(row_start_i)))
		else $error("window wrap wrong");
	a_on_start: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [RQ9]
		(cmd_on && pwr == PWR_OFF) |=> (pwr == PWR_WAIT) ##1 !display_on_o)
		else $error("display-on did not start delay");
	a_on_early: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [RQ9]
		(pwr == PWR_WAIT && timer < TW'(ON_DELAY_CYCLES - 1)) |=> !display_on_o)
		else $error("drivers enabled early");
	a_on_late: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [RQ9]
		(pwr == PWR_WAIT && timer == TW'(ON_DELAY_CYCLES - 1) && !cmd_off) |=> display_on_o)
		else $error("drivers not enabled after delay");
	a_off_now: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [RQ9]
		cmd_off |=> !display_on_o && (pwr == PWR_OFF))
		else $error("display-off not immediate");
	a_scan_latency: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [RQ1]
		scan_req_i |-> ##2 pixel_valid_o)
		else $error("pixel not returned in two cycles");
	a_write_window: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // [RQ6]
		wr_en |-> (ptr.col <= col_end_i) && (ptr.row <= row_end_i) && !scan_req_i)
		else $error("write outside window");
endmodule : dram_core
`default_nettype wire

// File: tb/dram_host_model.sv
// Host side model: frames command and data bytes onto the serial link
`timescale 1ns/10ps
`default_nettype none
module dram_host_model (
	input  wire logic sys_clk_i,
	output logic      sclk_o,
	output logic      sdin_o,
	output logic      dc_o,
	output logic      cs_n_o
);
	// Link idles deselected with its clock parked high
	initial
	begin
		sclk_o = 1'b1;
		sdin_o = 1'b0;
		dc_o   = 1'b0;
		cs_n_o = 1'b1;
	end

	// Half of the 320 ns link period
	task automatic half_period();
		repeat (4) @(negedge sys_clk_i);
	endtask : half_period

	// One byte per frame, MSB first, changes on falling edges
	// flag held across byte
	task automatic send_byte(input logic is_data, input logic [7:0] value);
		@(negedge sys_clk_i);
		dc_o   = is_data;
		cs_n_o = 1'b0;
		for (int i = 7; i >= 0; i--)
		begin
			sclk_o = 1'b0;
			sdin_o = value[i];
			half_period();
			sclk_o = 1'b1;
			half_period();
		end
		// Released lines show inverted levels, so stale values never pass
		cs_n_o = 1'b1;
		sdin_o = ~value[0];
		dc_o   = ~is_data;
		half_period();
	endtask : send_byte
endmodule : dram_host_model
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the display RAM address mapper
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import dram_pkg::*;
;
	localparam int ON_DLY = 20;
	typedef struct packed {
		logic             vert;
		logic [COL_W-1:0] cs;
		logic [ROW_W-1:0] rs;
		logic             colr;
		logic             nibr;
		logic             comr;
		logic [ROW_W-1:0] start;
		logic [SEG_W-1:0] column_driver_output;
		logic [ROW_W-1:0] row_driver_output;
		logic [3:0]       expd;
	} dram_case_t;
	// Each row writes 21h then 43h from the window start, then reads one pixel
	dram_case_t cases [8] = '{
		'{1'b0, 6'h00, 7'h00, 1'b0, 1'b0, 1'b0, 7'h00, 7'h02, 7'h00, 4'h3},
		'{1'b0, 6'h00, 7'h00, 1'b0, 1'b0, 1'b0, 7'h00, 7'h03, 7'h00, 4'h4},
		'{1'b1, 6'h05, 7'h0A, 1'b0, 1'b0, 1'b0, 7'h00, 7'h0A, 7'h0B, 4'h3},
		'{1'b0, 6'h00, 7'h00, 1'b1, 1'b1, 1'b0, 7'h00, 7'h7F, 7'h00, 4'h1},
		'{1'b0, 6'h00, 7'h00, 1'b1, 1'b1, 1'b0, 7'h00, 7'h7E, 7'h00, 4'h2},
		'{1'b0, 6'h00, 7'h00, 1'b0, 1'b0, 1'b1, 7'h10, 7'h00, 7'h0F, 4'h1},
		'{1'b0, 6'h00, 7'h00, 1'b0, 1'b0, 1'b0, 7'h01, 7'h01, 7'h4F, 4'h2},
		'{1'b0, 6'h3F, 7'h00, 1'b0, 1'b0, 1'b0, 7'h00, 7'h7E, 7'h01, 4'h3}
	};
	logic             clk;
	logic             rst_n;
	logic             sclk;
	logic             sdin;
	logic             dc;
	logic             cs_n;
	logic             vert;
	logic             colr;
	logic             nibr;
	logic             comr;
	logic [ROW_W-1:0] start;
	logic [COL_W-1:0] col_start;
	logic [ROW_W-1:0] row_start;
	logic [COL_W-1:0] col_end;
	logic [ROW_W-1:0] row_end;
	logic             reload;
	logic             scan_req;
	logic [ROW_W-1:0] scan_com;
	logic [SEG_W-1:0] scan_seg;
	logic [3:0]       pixel_o;
	logic             pixel_valid_o;
	logic             display_on_o;
	logic [7:0]       cmd_byte_o;
	logic             cmd_strobe_o;
	logic             overrun_o;
	int               n_fail = 0;
	int               cmp_count = 0;
	int               k;

	// 25 MHz system clock
	initial clk = 1'b0;
	always #20 clk = ~clk;

	dram_host_model host_i (.sys_clk_i(clk), .sclk_o(sclk), .sdin_o(sdin), .dc_o(dc), .cs_n_o(cs_n));

	dram_core #(.ON_DELAY_CYCLES(ON_DLY)) dram_core_i (
		.sys_clk_i(clk), .nrst_i(rst_n), .sclk_i(sclk), .sdin_i(sdin), .dc_i(dc), .cs_n_i(cs_n),
		.incr_vertical_i(vert), .col_remap_i(colr), .nibble_remap_i(nibr), .com_remap_i(comr),
		.start_line_i(start), .col_start_i(col_start), .col_end_i(col_end), .row_start_i(row_start),
		.row_end_i(row_end), .addr_reload_i(reload), .scan_req_i(scan_req),
		.scan_com_i(scan_com), .scan_seg_i(scan_seg), .pixel_o(pixel_o), .pixel_valid_o(pixel_valid_o),
		.display_on_o(display_on_o), .cmd_byte_o(cmd_byte_o), .cmd_strobe_o(cmd_strobe_o),
		.overrun_o(overrun_o));

	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done

	task automatic check(input logic [7:0] seen, input logic [7:0] expd, input string what);
		cmp_count++;
		if (seen !== expd)
		begin
			n_fail++;
			$display("Error at %0t: %s seen %0h expected %0h", $time, what, seen, expd);
		end
	endtask : check

	task automatic step(input int n);
		repeat (n) @(negedge clk);
	endtask : step

	// Bounded wait for a command strobe; a miss ends the run
	task automatic wait_strobe();
		for (k = 0; k < 300 && cmd_strobe_o !== 1'b1; k++)
			step(1);
		if (k == 300)
		begin
			n_fail++;
			$display("Error at %0t: no command strobe", $time);
			test_done();
		end
	endtask : wait_strobe

	// The strobe comes and goes before the frame's tail ends, so it is watched alongside the frame
	task automatic send_cmd(input logic [7:0] value);
		fork
			host_i.send_byte(1'b0, value);
			wait_strobe();
		join
	endtask : send_cmd

	// Valid must be up one edge after the taking edge
	task automatic scan(input logic [SEG_W-1:0] column_driver_output, input logic [ROW_W-1:0] row_driver_output, input logic [3:0] expd);
		scan_req = 1'b1;
		scan_seg = column_driver_output;
		scan_com = row_driver_output;
		step(1);
		scan_req = 1'b0;
		step(1);
		check(8'(pixel_valid_o), 8'h01, "pixel valid");
		check(8'(pixel_o), 8'(expd), "pixel");
	endtask : scan

	// Watchdog against a hang
	initial
	begin
		step(60000);
		n_fail++;
		$display("Error at %0t: timeout", $time);
		test_done();
	end

	initial
	begin
		{rst_n, vert, colr, nibr, comr, reload, scan_req} = '0;
		{start, col_start, row_start, scan_com, scan_seg} = '0;
		col_end = COL_LAST;
		row_end = ROW_LAST_B[ROW_W-1:0];
		step(2);
		rst_n = 1'b1;
		step(1);
		check(8'(display_on_o), 8'h00, "display on after reset");
		check(8'(overrun_o), 8'h00, "overrun after reset");
		check(8'(cmd_strobe_o), 8'h00, "strobe after reset");
		step(3);
		// Ordinary mapping cases
		foreach (cases[i])
		begin
			{vert, col_start, row_start, colr, nibr, comr, start} = {cases[i].vert, cases[i].cs,
				cases[i].rs, cases[i].colr, cases[i].nibr, cases[i].comr, cases[i].start};
			reload = 1'b1;
			step(1);
			reload = 1'b0;
			host_i.send_byte(1'b1, 8'h21);
			host_i.send_byte(1'b1, 8'h43);
			step(12);
			scan(cases[i].column_driver_output, cases[i].row_driver_output, cases[i].expd);
		end
		// Two by two window: fifth byte wraps onto the first, a byte outside the window is dropped
		{col_start, col_end, row_start, row_end} = {6'h01, 6'h02, 7'h01, 7'h02};
		reload = 1'b1;
		step(1);
		reload = 1'b0;
		for (int j = 1; j <= 5; j++)
			host_i.send_byte(1'b1, 8'(j) * 8'h11);
		col_end = 6'h01;
		host_i.send_byte(1'b1, 8'h66);
		step(12);
		scan(7'h02, 7'h01, 4'h5);
		scan(7'h05, 7'h02, 4'h4);
		scan(7'h04, 7'h01, 4'h2);
		// Display on delay, repeated on ignored, then off
		fork
			host_i.send_byte(1'b0, CMD_DISPLAY_ON);
			begin
				wait_strobe();
				check(cmd_byte_o, CMD_DISPLAY_ON, "command byte");
				for (k = 0; k < 1000 && display_on_o !== 1'b1; k++)
					step(1);
			end
		join
		check(8'(k), 8'(ON_DLY), "display on delay");
		if (k == 1000)
			test_done();
		send_cmd(CMD_DISPLAY_ON);
		check(8'(display_on_o), 8'h01, "display on held");
		send_cmd(CMD_DISPLAY_OFF);
		check(8'(display_on_o), 8'h00, "display off");
		// Fill buffer with drain stalled; holding slot takes one more
		scan_req = 1'b1;
		repeat (17) host_i.send_byte(1'b1, 8'h5A);
		step(12);
		check(8'(overrun_o), 8'h00, "no overrun at full");
		host_i.send_byte(1'b1, 8'hA5);
		step(12);
		check(8'(overrun_o), 8'h01, "overrun");
		scan_req = 1'b0;
		step(40);
		check(cmd_byte_o, CMD_DISPLAY_OFF, "data left command alone");
		send_cmd(CMD_DISPLAY_ON);
		check(cmd_byte_o, CMD_DISPLAY_ON, "command after drain");
		// Mid-run reset clears sticky overrun and drivers; link must work again after it
		// reset held 3 us
		rst_n = 1'b0;
		step(75);
		check(8'(overrun_o), 8'h00, "overrun after mid reset");
		check(8'(display_on_o), 8'h00, "display on after mid reset");
		rst_n = 1'b1;
		step(75);
		send_cmd(CMD_DISPLAY_OFF);
		check(cmd_byte_o, CMD_DISPLAY_OFF, "command after mid reset");
		test_done();
	end
endmodule : tb_top
`default_nettype wire
